/* src/uvp_pkg.sv */
// Package with register map, field positions and packet constants
package uvp_pkg;

	// Register byte addresses
	localparam logic [11:0] ADDR_UVID = 12'h0328;
	localparam logic [11:0] ADDR_MAC0 = 12'h0330;
	localparam logic [11:0] ADDR_MAC1 = 12'h0334;
	localparam logic [11:0] ADDR_STAT = 12'h0338;

	// Unknown VLAN forward control fields
	localparam int          UVID_EN_BIT  = 31;
	localparam int          UVID_PORT_HI = 6;
	localparam logic        UVID_EN_RST  = 1'b0;
	localparam logic [6:0]  UVID_PORT_RST = 7'h00;

	// MAC policy control 0 fields
	localparam int          MAC0_ALT_BIT  = 7;
	localparam int          MAC0_LEN_BIT  = 3;
	localparam int          MAC0_FC_BIT   = 1;
	localparam int          MAC0_AGGR_BIT = 0;
	localparam logic [7:0]  MAC0_RST      = 8'h04;

	// Excessive collision control field
	localparam int          MAC1_NODROP_BIT = 0;
	localparam logic        MAC1_NODROP_RST = 1'b0;

	// Counter layout of the status word
	localparam int          STAT_FC_LO  = 0;
	localparam int          STAT_LEN_LO = 8;
	localparam int          STAT_VID_LO = 16;

	// Packet constants
	localparam int           NUM_PORTS   = 7;
	localparam logic [15:0]  PAUSE_ETYPE = 16'h8808;
	localparam logic [47:0]  PAUSE_DA    = 48'h0180_C200_0001;
	localparam logic [15:0]  LEN_LIMIT   = 16'h05DC;

	// Packet category after precedence
	typedef enum logic [1:0] {
		CAT_NONE,
		CAT_VID,
		CAT_UCAST,
		CAT_MCAST
	} uvp_cat_t;

endpackage : uvp_pkg

/* src/uvp_pol_if.sv */
// Interface between register side and decision engine
`timescale 1ns/1ps
interface uvp_pol_if;
	import uvp_pkg::*;

	// Policy state
	logic                 vid_en;
	logic [NUM_PORTS-1:0] vid_ports;
	logic                 len_chk;
	logic                 fc_mode;

	// Packet descriptor
	logic                 vid_unknown;
	logic                 uc_unknown;
	logic                 mc_unknown;
	logic [15:0]          etype;
	logic [47:0]          da;
	logic [15:0]          len;

	// Decision
	uvp_cat_t             cat;
	logic                 drop;
	logic                 drop_fc;
	logic                 drop_len;
	logic [NUM_PORTS-1:0] ports;

	modport eng (
		input  vid_en, vid_ports, len_chk, fc_mode,
		input  vid_unknown, uc_unknown, mc_unknown, etype, da, len,
		output cat, drop, drop_fc, drop_len, ports
	);

	modport top (
		output vid_en, vid_ports, len_chk, fc_mode,
		output vid_unknown, uc_unknown, mc_unknown, etype, da, len,
		input  cat, drop, drop_fc, drop_len, ports
	);

endinterface : uvp_pol_if

/* src/uvp_decide.sv */
// Combinational per-packet policy decision
`timescale 1ns/1ps
module uvp_decide
	import uvp_pkg::*;
(
	// Policy and packet
	uvp_pol_if.eng pol
);

	logic fc_type;
	logic fc_da;
	logic fc_hit;
	logic len_hit;
	logic vid_block;

	// Pause frame match
	assign fc_type = (pol.etype == PAUSE_ETYPE);
	assign fc_da   = (pol.da == PAUSE_DA);
	assign fc_hit  = pol.fc_mode ? (fc_type | fc_da)
	                             : (fc_type & fc_da);

	// Length field check
	assign len_hit = pol.len_chk && (pol.etype < LEN_LIMIT)
	                 && (pol.len != pol.etype);

	// Category precedence
	always_comb begin
		if (pol.vid_unknown) begin
			pol.cat = CAT_VID;
		end else if (pol.uc_unknown) begin
			pol.cat = CAT_UCAST;
		end else if (pol.mc_unknown) begin
			pol.cat = CAT_MCAST;
		end else begin
			pol.cat = CAT_NONE;
		end
	end

	assign vid_block    = (pol.cat == CAT_VID) && !pol.vid_en;
	assign pol.drop_fc  = fc_hit;
	assign pol.drop_len = len_hit;
	assign pol.drop     = fc_hit | len_hit | vid_block;

	// Port mask forwarding
	assign pol.ports = ((pol.cat == CAT_VID) && pol.vid_en && !pol.drop)
	                   ? pol.vid_ports
	                   : {NUM_PORTS{1'b0}};

endmodule : uvp_decide

/* src/uvp_policy_top.sv */
// Unknown VLAN forwarding and MAC policy register bank
`timescale 1ns/1ps
// Overview of operation
// - Enabled unknown-VLAN forwarding sends packets only to masked ports.
// - Forwarding off at reset; unknown-VLAN packets are not mask-forwarded.
// - Mask bits 6:0 map bit 0 to port 1, bit 1 to port 2.
// - All-ones mask reaches every port, all-zeros mask reaches none.
// - Unknown VLAN precedes unknown unicast, then unknown multicast.
// - Alternate back-off bit 7 applies only to half-duplex ports.
// - No-drop setting keeps packets after 16 collisions, else they drop.
// - Length check bit 3 drops length mismatch when field is below 1500.
// - Drop mode bit 1 set drops pause ethertype or pause address.
// - Drop mode bit clear drops only pause ethertype with pause address.
// - Aggressive back-off bit 0 enables it for half-duplex back pressure.
module uvp_policy_top
	import uvp_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [11:0]          wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output      logic [31:0]          wb_dat_o,
	output      logic                 wb_ack_o,
	// Packet descriptor
	input  wire logic                 pkt_valid_i,
	input  wire logic                 pkt_vid_unknown_i,
	input  wire logic                 pkt_uc_unknown_i,
	input  wire logic                 pkt_mc_unknown_i,
	input  wire logic [15:0]          pkt_etype_i,
	input  wire logic [47:0]          pkt_da_i,
	input  wire logic [15:0]          pkt_len_i,
	// Decision
	output      logic                 dec_valid_o,
	output      logic [1:0]           dec_cat_o,
	output      logic                 dec_drop_o,
	output      logic                 dec_drop_fc_o,
	output      logic                 dec_drop_len_o,
	output      logic [NUM_PORTS-1:0] dec_ports_o,
	// Per-port MAC controls
	input  wire logic [NUM_PORTS-1:0] port_half_dup_i,
	input  wire logic [NUM_PORTS-1:0] port_col16_i,
	output      logic [NUM_PORTS-1:0] port_alt_backoff_o,
	output      logic [NUM_PORTS-1:0] port_aggr_backoff_o,
	output      logic [NUM_PORTS-1:0] port_col_drop_o,
	output      logic [NUM_PORTS-1:0] port_col_keep_o
);

	// Register state
	logic                 vid_en;
	logic [NUM_PORTS-1:0] vid_ports;
	logic [7:0]           mac0;
	logic                 no_col_drop;
	logic [7:0]           fc_cnt;
	logic [7:0]           len_cnt;
	logic [7:0]           vid_cnt;

	// Bus decode
	logic                 bus_req;
	logic                 wr_stb;
	logic                 hit_uvid;
	logic                 hit_mac0;
	logic                 hit_mac1;
	logic                 hit_stat;
	logic [31:0]          next_rdata;

	uvp_pol_if pol ();

	// Policy and packet onto the engine
	assign pol.vid_en      = vid_en;
	assign pol.vid_ports   = vid_ports;
	assign pol.len_chk     = mac0[MAC0_LEN_BIT];
	assign pol.fc_mode     = mac0[MAC0_FC_BIT];
	assign pol.vid_unknown = pkt_vid_unknown_i;
	assign pol.uc_unknown  = pkt_uc_unknown_i;
	assign pol.mc_unknown  = pkt_mc_unknown_i;
	assign pol.etype       = pkt_etype_i;
	assign pol.da          = pkt_da_i;
	assign pol.len         = pkt_len_i;

	uvp_decide u_decide (
		.pol (pol)
	);

	// Address decode
	assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_stb   = bus_req && wb_we_i;
	assign hit_uvid = (wb_adr_i[11:2] == ADDR_UVID[11:2]);
	assign hit_mac0 = (wb_adr_i[11:2] == ADDR_MAC0[11:2]);
	assign hit_mac1 = (wb_adr_i[11:2] == ADDR_MAC1[11:2]);
	assign hit_stat = (wb_adr_i[11:2] == ADDR_STAT[11:2]);

	// Acknowledge one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// Unknown VLAN forward control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vid_en    <= UVID_EN_RST;
			vid_ports <= UVID_PORT_RST;
		end else if (wr_stb && hit_uvid) begin
			if (wb_sel_i[3]) begin
				vid_en <= wb_dat_i[UVID_EN_BIT];
			end
			if (wb_sel_i[0]) begin
				vid_ports <= wb_dat_i[UVID_PORT_HI:0];
			end
		end
	end

	// MAC policy control 0
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mac0 <= MAC0_RST;
		end else if (wr_stb && hit_mac0 && wb_sel_i[0]) begin
			mac0 <= wb_dat_i[7:0];
		end
	end

	// Excessive collision control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			no_col_drop <= MAC1_NODROP_RST;
		end else if (wr_stb && hit_mac1 && wb_sel_i[0]) begin
			no_col_drop <= wb_dat_i[MAC1_NODROP_BIT];
		end
	end

	// Read data
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit_uvid) begin
			next_rdata = {vid_en, 24'h00_0000, vid_ports};
		end else if (hit_mac0) begin
			next_rdata = {24'h00_0000, mac0};
		end else if (hit_mac1) begin
			next_rdata = {31'h0000_0000, no_col_drop};
		end else if (hit_stat) begin
			next_rdata = {8'h00, vid_cnt, len_cnt, fc_cnt};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end

	// Decision register, sampled with policy of the arrival cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dec_valid_o    <= 1'b0;
			dec_cat_o      <= 2'h0;
			dec_drop_o     <= 1'b0;
			dec_drop_fc_o  <= 1'b0;
			dec_drop_len_o <= 1'b0;
			dec_ports_o    <= {NUM_PORTS{1'b0}};
		end else begin
			dec_valid_o <= pkt_valid_i;
			if (pkt_valid_i) begin
				dec_cat_o      <= pol.cat;
				dec_drop_o     <= pol.drop;
				dec_drop_fc_o  <= pol.drop_fc;
				dec_drop_len_o <= pol.drop_len;
				dec_ports_o    <= pol.ports;
			end
		end
	end

	// Drop and forward counters
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fc_cnt  <= 8'h00;
			len_cnt <= 8'h00;
			vid_cnt <= 8'h00;
		end else if (pkt_valid_i) begin
			if (pol.drop_fc) begin
				fc_cnt <= fc_cnt + 8'h01;
			end
			if (pol.drop_len) begin
				len_cnt <= len_cnt + 8'h01;
			end
			if (pol.cat == CAT_VID && !pol.drop) begin
				vid_cnt <= vid_cnt + 8'h01;
			end
		end
	end

	// Per-port back-off and collision controls
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					port_alt_backoff_o[p]  <= 1'b0;
					port_aggr_backoff_o[p] <= 1'b0;
					port_col_drop_o[p]     <= 1'b0;
					port_col_keep_o[p]     <= 1'b0;
				end else begin
					port_alt_backoff_o[p] <= mac0[MAC0_ALT_BIT]
					                         && port_half_dup_i[p];
					port_aggr_backoff_o[p] <= mac0[MAC0_AGGR_BIT]
					                          && port_half_dup_i[p];
					port_col_drop_o[p] <= port_col16_i[p]
					                      && !no_col_drop;
					port_col_keep_o[p] <= port_col16_i[p]
					                      && no_col_drop;
				end
			end
		end
	endgenerate

	// Checks
	chk_vid_mask_fwd : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(pkt_valid_i && pkt_vid_unknown_i && vid_en
		 && !pol.drop_fc && !pol.drop_len)
		|=> (dec_ports_o == $past(vid_ports)) && !dec_drop_o)
		else $error("unknown vlan packet not sent to mask");

	chk_vid_fwd_off : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(pkt_valid_i && pkt_vid_unknown_i && !vid_en)
		|=> dec_drop_o && (dec_ports_o == {NUM_PORTS{1'b0}}))
		else $error("disabled unknown vlan packet forwarded");

	chk_mask_port_map : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(wr_stb && hit_uvid && wb_sel_i[0])
		|=> vid_ports == $past(wb_dat_i[UVID_PORT_HI:0]))
		else $error("port mask bit order wrong");

	chk_mask_all_ones : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(pkt_valid_i && pkt_vid_unknown_i && vid_en && !pol.drop
		 && (&vid_ports))
		|=> (&dec_ports_o))
		else $error("all ones mask missed a port");

	chk_cat_order : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(pkt_valid_i && (pkt_vid_unknown_i || pkt_uc_unknown_i
		 || pkt_mc_unknown_i))
		|=> dec_cat_o == ($past(pkt_vid_unknown_i) ? 2'(CAT_VID)
		    : $past(pkt_uc_unknown_i) ? 2'(CAT_UCAST)
		    : 2'(CAT_MCAST)))
		else $error("unknown category precedence wrong");

	chk_alt_half_dup : assert property (
		@(posedge clk_i) disable iff (rst_i)
		##1 (port_alt_backoff_o ==
		     ($past(port_half_dup_i)
		      & {NUM_PORTS{$past(mac0[MAC0_ALT_BIT])}})))
		else $error("alternate back-off on full duplex port");

	chk_col_drop : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(|port_col16_i)
		|=> (port_col_drop_o | port_col_keep_o) == $past(port_col16_i)
		    && ((|port_col_drop_o) != $past(no_col_drop)))
		else $error("excessive collision handling wrong");

	chk_len_discard : assert property (
		@(posedge clk_i) disable iff (rst_i)
		pkt_valid_i
		|=> dec_drop_len_o == ($past(mac0[MAC0_LEN_BIT])
		    && ($past(pkt_etype_i) < LEN_LIMIT)
		    && ($past(pkt_len_i) != $past(pkt_etype_i))))
		else $error("length field check wrong");

	chk_fc_either : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(pkt_valid_i && mac0[MAC0_FC_BIT]
		 && ((pkt_etype_i == PAUSE_ETYPE) || (pkt_da_i == PAUSE_DA)))
		|=> dec_drop_fc_o && dec_drop_o)
		else $error("pause packet not dropped in either mode");

	chk_fc_both : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(pkt_valid_i && !mac0[MAC0_FC_BIT])
		|=> dec_drop_fc_o == ($past(pkt_etype_i) == PAUSE_ETYPE
		                      && $past(pkt_da_i) == PAUSE_DA))
		else $error("pause drop in both mode wrong");

	chk_aggr_half_dup : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(|port_half_dup_i)
		|=> port_aggr_backoff_o == ($past(port_half_dup_i)
		    & {NUM_PORTS{$past(mac0[MAC0_AGGR_BIT])}}))
		else $error("aggressive back-off not applied");

	chk_write_effect : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(wr_stb && hit_mac0 && wb_sel_i[0])
		|=> (mac0 == $past(wb_dat_i[7:0])) && wb_ack_o)
		else $error("policy write not in place at ack");

	chk_mask_all_zero : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(pkt_valid_i && pkt_vid_unknown_i && vid_en
		 && (vid_ports == {NUM_PORTS{1'b0}}))
		|=> (dec_ports_o == {NUM_PORTS{1'b0}}))
		else $error("all zeros mask reached a port");

	chk_known_vid_ports : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(pkt_valid_i && !pkt_vid_unknown_i)
		|=> (dec_ports_o == {NUM_PORTS{1'b0}}))
		else $error("mask used for a known vlan packet");

	chk_reset_values : assert property (
		@(posedge clk_i)
		$fell(rst_i)
		|-> (vid_en == UVID_EN_RST) && (vid_ports == UVID_PORT_RST)
		    && (mac0 == MAC0_RST) && !wb_ack_o)
		else $error("register not at reset value");

	chk_len_count : assert property (
		@(posedge clk_i) disable iff (rst_i)
		(pkt_valid_i && pol.drop_len)
		|=> len_cnt == $past(len_cnt) + 8'h01)
		else $error("length drop count not advanced");

	chk_ack_pulse : assert property (
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

endmodule : uvp_policy_top

/* bench/tb_uvp_policy_top.sv */
// Self-checking bench for the unknown VLAN and MAC policy bank
`timescale 1ns/1ps
module tb_uvp_policy_top;
	import uvp_pkg::*;

	typedef struct packed {
		logic [1:0] cat;
		logic       drop;
		logic       fc;
		logic       ln;
		logic [6:0] ports;
	} uvp_exp_t;

	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic        pkt_valid_i, pkt_vid_unknown_i, pkt_uc_unknown_i;
	logic        pkt_mc_unknown_i, dec_valid_o, dec_drop_o;
	logic        dec_drop_fc_o, dec_drop_len_o;
	logic [15:0] pkt_etype_i, pkt_len_i;
	logic [47:0] pkt_da_i;
	logic [1:0]  dec_cat_o;
	logic [6:0]  dec_ports_o, port_half_dup_i, port_col16_i;
	logic [6:0]  port_alt_backoff_o, port_aggr_backoff_o;
	logic [6:0]  port_col_drop_o, port_col_keep_o;
	logic        en, fcm, lchk;
	logic [6:0]  msk;
	logic [7:0]  n_fc, n_ln, n_vf;
	uvp_exp_t    exp_q[$];
	logic [31:0] rd_q[$];
	int          n_fail, checks;

	uvp_policy_top u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .pkt_valid_i(pkt_valid_i),
		.pkt_vid_unknown_i(pkt_vid_unknown_i),
		.pkt_uc_unknown_i(pkt_uc_unknown_i),
		.pkt_mc_unknown_i(pkt_mc_unknown_i), .pkt_etype_i(pkt_etype_i),
		.pkt_da_i(pkt_da_i), .pkt_len_i(pkt_len_i),
		.dec_valid_o(dec_valid_o), .dec_cat_o(dec_cat_o),
		.dec_drop_o(dec_drop_o), .dec_drop_fc_o(dec_drop_fc_o),
		.dec_drop_len_o(dec_drop_len_o), .dec_ports_o(dec_ports_o),
		.port_half_dup_i(port_half_dup_i), .port_col16_i(port_col16_i),
		.port_alt_backoff_o(port_alt_backoff_o),
		.port_aggr_backoff_o(port_aggr_backoff_o),
		.port_col_drop_o(port_col_drop_o),
		.port_col_keep_o(port_col_keep_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask : chk

	task wrap_up;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// Expected decision from shadow register state
	function automatic uvp_exp_t model(input logic v, u, m,
		input logic [15:0] et, input logic [47:0] da, input logic [15:0] ln);
		uvp_exp_t r;
		logic     e, d;
		e = (et == PAUSE_ETYPE);
		d = (da == PAUSE_DA);
		r.cat = v ? 2'h1 : u ? 2'h2 : m ? 2'h3 : 2'h0;
		r.fc = fcm ? (e | d) : (e & d);
		r.ln = lchk && (et < LEN_LIMIT) && (ln != et);
		r.drop = r.fc | r.ln | (v & ~en);
		r.ports = (v && en && !r.drop) ? msk : 7'h00;
		return r;
	endfunction : model

	// Classic single Wishbone cycle, waits for ack
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [3:0] s, input logic [31:0] d, input logic [31:0] e);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		if (!w)
			rd_q.push_back(e);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			chk(32'h0000_0000, 32'h0000_0001, "no ack");
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic cfg(input logic [31:0] u, input logic [7:0] m);
		bus(1'b1, ADDR_UVID, 4'hf, u, 32'h0000_0000);
		bus(1'b1, ADDR_MAC0, 4'hf, {24'h00_0000, m}, 32'h0000_0000);
		en = u[31];
		msk = u[6:0];
		fcm = m[1];
		lchk = m[3];
	endtask : cfg

	// Presents one packet; valid stays high for back to back packets
	task automatic pkt(input logic [2:0] f, input logic [15:0] et,
		input logic [47:0] da, input logic [15:0] ln);
		uvp_exp_t r;
		@(posedge clk_i);
		pkt_valid_i <= 1'b1;
		{pkt_vid_unknown_i, pkt_uc_unknown_i, pkt_mc_unknown_i} <= f;
		pkt_etype_i <= et;
		pkt_da_i <= da;
		pkt_len_i <= ln;
		r = model(f[2], f[1], f[0], et, da, ln);
		exp_q.push_back(r);
		n_fc = n_fc + 8'(r.fc);
		n_ln = n_ln + 8'(r.ln);
		n_vf = n_vf + 8'(f[2] && !r.drop);
	endtask : pkt

	task automatic idle;
		@(posedge clk_i);
		pkt_valid_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : idle

	task automatic prand;
		logic [31:0] k;
		logic [15:0] et;
		k = $urandom;
		et = k[1] ? PAUSE_ETYPE : {5'h00, k[12:2]};
		pkt(k[6:4], et, k[3] ? PAUSE_DA : {k, k[31:16]},
			k[7] ? et : {8'h00, k[23:16]});
	endtask : prand

	// Per-port back-off and collision outputs
	task automatic port_test(input logic [7:0] m0, input logic nd);
		logic [6:0] hd, cv;
		hd = 7'($urandom);
		cv = 7'($urandom);
		bus(1'b1, ADDR_MAC0, 4'hf, {24'h00_0000, m0}, 32'h0000_0000);
		bus(1'b1, ADDR_MAC1, 4'hf, {31'h0000_0000, nd}, 32'h0000_0000);
		@(posedge clk_i);
		port_half_dup_i <= hd;
		port_col16_i <= cv;
		@(posedge clk_i);
		port_col16_i <= 7'h00;
		@(negedge clk_i);
		chk(port_col_drop_o, nd ? 7'h00 : cv, "collision drop");
		chk(port_col_keep_o, nd ? cv : 7'h00, "collision keep");
		chk(port_alt_backoff_o, m0[7] ? hd : 7'h00, "alt backoff");
		chk(port_aggr_backoff_o, m0[0] ? hd : 7'h00, "aggr backoff");
		@(negedge clk_i);
		chk(port_col_drop_o | port_col_keep_o, 32'h0000_0000, "col pulse");
	endtask : port_test

	// Result monitor: oldest note against each answer
	always @(posedge clk_i) begin
		if (dec_valid_o === 1'b1) begin
			if (exp_q.size() == 0)
				chk(32'h0000_0000, 32'h0000_0001, "stray decision");
			else
				chk({dec_cat_o, dec_drop_o, dec_drop_fc_o, dec_drop_len_o,
					dec_ports_o}, exp_q.pop_front(), "decision");
		end
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() != 0)
			chk(wb_dat_o, rd_q.pop_front(), "read data");
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		wrap_up();
	end

	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pkt_valid_i} = 5'h10;
		{wb_adr_i, wb_sel_i, wb_dat_i, pkt_etype_i, pkt_len_i} = '0;
		{pkt_vid_unknown_i, pkt_uc_unknown_i, pkt_mc_unknown_i} = 3'h0;
		{pkt_da_i, port_half_dup_i, port_col16_i} = '0;
		{en, fcm, lchk, msk, n_fc, n_ln, n_vf} = '0;
		n_fail = 0;
		checks = 0;
		void'($urandom(32'h1d3e));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, ADDR_UVID, 4'hf, 32'h0000_0000, 32'h0000_0000);
		bus(1'b0, ADDR_MAC0, 4'hf, 32'h0000_0000, 32'h0000_0004);
		bus(1'b0, ADDR_MAC1, 4'hf, 32'h0000_0000, 32'h0000_0000);
		bus(1'b0, ADDR_STAT, 4'hf, 32'h0000_0000, 32'h0000_0000);
		bus(1'b1, ADDR_UVID, 4'hf, 32'hffff_ffff, 32'h0000_0000);
		bus(1'b0, ADDR_UVID, 4'hf, 32'h0000_0000, 32'h8000_007f);
		bus(1'b1, ADDR_UVID, 4'h1, 32'h0000_0000, 32'h0000_0000);
		bus(1'b0, ADDR_UVID, 4'hf, 32'h0000_0000, 32'h8000_0000);
		bus(1'b1, 12'h0400, 4'hf, 32'hffff_ffff, 32'h0000_0000);
		bus(1'b0, 12'h0400, 4'hf, 32'h0000_0000, 32'h0000_0000);
		bus(1'b1, ADDR_MAC0, 4'hf, 32'h0000_00ff, 32'h0000_0000);
		bus(1'b0, ADDR_MAC0, 4'hf, 32'h0000_0000, 32'h0000_00ff);
		$display("test registers done");
		cfg(32'h0000_007f, 8'h04);
		pkt(3'h7, 16'h0800, 48'h0000_0000_0001, 16'h0040);
		idle();
		for (int i = 0; i < 9; i++) begin
			cfg({25'h100_0000, i < 7 ? 7'(1 << i) : i == 7 ? 7'h7f : 7'h00},
				8'h04);
			pkt(3'h4, 16'h0800, 48'h0000_0000_0002, 16'h0040);
			idle();
		end
		for (int i = 0; i < 8; i++)
			pkt(3'(i), 16'h0800, 48'h0000_0000_0003, 16'h0040);
		idle();
		$display("test forwarding done");
		for (int f = 0; f < 2; f++) begin
			cfg(32'h8000_007f, f ? 8'h06 : 8'h04);
			for (int k = 0; k < 4; k++)
				pkt(3'h4, k[0] ? PAUSE_ETYPE : 16'h0800,
					k[1] ? PAUSE_DA : 48'h0180_C200_0002, 16'h0040);
			idle();
		end
		cfg(32'h8000_0055, 8'h0c);
		pkt(3'h4, 16'h0064, 48'h0000_0000_0004, 16'h0064);
		pkt(3'h4, 16'h0064, 48'h0000_0000_0004, 16'h0065);
		pkt(3'h4, 16'h05dc, 48'h0000_0000_0004, 16'h0001);
		pkt(3'h4, 16'h05db, 48'h0000_0000_0004, 16'h0001);
		idle();
		cfg(32'h8000_0055, 8'h04);
		pkt(3'h4, 16'h0064, 48'h0000_0000_0004, 16'h0065);
		idle();
		$display("test drop modes done");
		for (int i = 0; i < 40; i++) begin
			cfg($urandom, 8'($urandom));
			repeat (3) prand();
			idle();
		end
		$display("test random done");
		bus(1'b0, ADDR_STAT, 4'hf, 32'h0000_0000,
			{8'h00, n_vf, n_ln, n_fc});
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		{en, fcm, lchk, msk, n_fc, n_ln, n_vf} = '0;
		bus(1'b0, ADDR_UVID, 4'hf, 32'h0000_0000, 32'h0000_0000);
		bus(1'b0, ADDR_MAC0, 4'hf, 32'h0000_0000, 32'h0000_0004);
		bus(1'b0, ADDR_STAT, 4'hf, 32'h0000_0000, 32'h0000_0000);
		$display("test status and reset done");
		for (int k = 0; k < 4; k++)
			port_test({k[1], 6'h02, k[0]}, k[1] & k[0]);
		$display("test port controls done");
		chk(exp_q.size() + rd_q.size(), 32'h0000_0000, "missing answers");
		wrap_up();
	end
endmodule : tb_uvp_policy_top
